// >>> design/hbt_core.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// - mode bits select off, dual SWI, full BACKGROUND_DEBUG_MODE, or dual BACKGROUND_DEBUG_MODE breakpoints.
// - program-only clear breaks at next boundary; set breaks only on executed opcode.
// - in dual SWI mode program-only is ignored; only executed-opcode breaks.
// - range bit 0 picks high-byte or full-word compare for breakpoint zero.
// - range bit 1 adds low-byte compare for breakpoint one in dual modes only.
// - data compare enable gates all use of the data match registers.
// - full mode byte masks drop data bits 15:8 or 7:0 from the compare.
// - breakpoint zero read/write qualifier: don't care, writes on 0, reads on 1.
// - breakpoint one read/write qualifier likewise, dual modes only.
// - address match high and low compare the address high and low bytes.
// - data match registers hit data bus in full mode, address bus in dual.
// - power-on reset clears four match registers; plain reset keeps them.
// - both control registers readable and writable at any time.
// - tag-and-go command arms tag inputs, latched with fetch at falling E.
// - tag pins independent, low marks its byte, both high no tag.
// - tagging ends on background entry; serial commands held while tagging.
// - tags ride the queue; tagged head enters background instead of executing.
// - low tag pin driven as low strobe a quarter cycle around rising E.
// - in dual modes data compare enable enables breakpoint one.
// - no breakpoint taken while background mode is active.
module hbt_core #(
   parameter int QUEUE_DEPTH = hbt_pkg::QUEUE_DEPTH_DEFAULT
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic powerOnReset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire hbt_pkg::hbt_cpu_t cpu,
   input wire logic bdmActive,
   input wire logic tagGoCommand,
   input wire logic tagHighPinIn,
   input wire logic tagLowPinIn,
   output logic lowStrobeOut,
   output logic lowStrobeOe_n,
   input wire logic swiAccept,
   input wire logic bdmAccept,
   output logic swiRequest,
   output logic bdmRequest,
   output logic tagEnable,
   output logic serialHold
);
   localparam int PW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;

   logic [7:0] control0;
   logic [7:0] control1;
   logic [7:0] addressHigh;
   logic [7:0] addressLow;
   logic [7:0] dataHigh;
   logic [7:0] dataLow;
   logic writePending;
   logic [7:0] writeAddr;
   logic breakPending;
   hbt_pkg::hbt_tag_t tagQueue [QUEUE_DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic [PW:0] fill;

   // bus decode
   wire addrPhase = hsel & htrans[1] & hready;
   wire [7:0] regAddr = haddr[7:0];
   wire mapped = (haddr[31:8] == 24'h000000) & (regAddr[1:0] == 2'h0);
   wire [7:0] statusByte = {4'h0, swiRequest, bdmRequest, breakPending, tagEnable};
   wire [7:0] readByte =
      !mapped ? 8'h00 :
      (regAddr == hbt_pkg::ADDR_CONTROL_0) ? control0 :
      (regAddr == hbt_pkg::ADDR_CONTROL_1) ? control1 :
      (regAddr == hbt_pkg::ADDR_ADDRESS_HIGH) ? addressHigh :
      (regAddr == hbt_pkg::ADDR_ADDRESS_LOW) ? addressLow :
      (regAddr == hbt_pkg::ADDR_DATA_HIGH) ? dataHigh :
      (regAddr == hbt_pkg::ADDR_DATA_LOW) ? dataLow :
      (regAddr == hbt_pkg::ADDR_STATUS) ? statusByte : 8'h00;
   wire [7:0] wrByte = hwdata[7:0];
   wire wrControl0 = writePending & (writeAddr == hbt_pkg::ADDR_CONTROL_0);
   wire wrControl1 = writePending & (writeAddr == hbt_pkg::ADDR_CONTROL_1);
   wire wrAddrHigh = writePending & (writeAddr == hbt_pkg::ADDR_ADDRESS_HIGH);
   wire wrAddrLow = writePending & (writeAddr == hbt_pkg::ADDR_ADDRESS_LOW);
   wire wrDataHigh = writePending & (writeAddr == hbt_pkg::ADDR_DATA_HIGH);
   wire wrDataLow = writePending & (writeAddr == hbt_pkg::ADDR_DATA_LOW);

   // control field decode
   wire [1:0] modeBits = {control0[hbt_pkg::MODE_ENABLE_HI_BIT], control0[hbt_pkg::MODE_ENABLE_LO_BIT]};
   wire swiDual = (modeBits == hbt_pkg::HBT_MODE_SWI_DUAL);
   wire bdmFull = (modeBits == hbt_pkg::HBT_MODE_BDM_FULL);
   wire bdmDual = (modeBits == hbt_pkg::HBT_MODE_BDM_DUAL);
   wire dualMode = swiDual | bdmDual;
   wire programOnly = swiDual | control0[hbt_pkg::PROGRAM_ONLY_SELECT_BIT];
   wire range0 = control0[hbt_pkg::RANGE_BIT_0_BIT];
   wire range1 = control0[hbt_pkg::RANGE_BIT_1_BIT];
   wire dataEnable = control1[hbt_pkg::DATA_COMPARE_ENABLE_BIT];
   wire maskHigh = control1[hbt_pkg::HIGH_BYTE_MASK_BIT];
   wire maskLow = control1[hbt_pkg::LOW_BYTE_MASK_BIT];
   // read/write qualifiers mean nothing in SWI mode or on program breaks
   wire rwUsable = !swiDual & !programOnly;
   wire rwEnable0 = control1[hbt_pkg::RW_COMPARE_ENABLE_0_BIT] & rwUsable;
   wire rwEnable1 = control1[hbt_pkg::RW_COMPARE_ENABLE_1_BIT] & rwUsable;
   wire rwValue0 = control1[hbt_pkg::RW_COMPARE_VALUE_0_BIT];
   wire rwValue1 = control1[hbt_pkg::RW_COMPARE_VALUE_1_BIT];

   // comparators
   wire addrHighHit0 = (cpu.addr[15:8] == addressHigh);
   wire addrLowHit0 = !range0 | (cpu.addr[7:0] == addressLow);
   wire rwHit0 = !rwEnable0 | (cpu.rw == rwValue0);
   wire bp0Hit = addrHighHit0 & addrLowHit0 & rwHit0;
   wire dataHighHit = maskHigh | (cpu.data[15:8] == dataHigh);
   wire dataLowHit = maskLow | (cpu.data[7:0] == dataLow);
   // masks only act with the data compare on and not on program breaks
   wire dataHit = !dataEnable | programOnly | (dataHighHit & dataLowHit);
   wire fullHit = bdmFull & bp0Hit & dataHit;
   wire addrHighHit1 = (cpu.addr[15:8] == dataHigh);
   wire addrLowHit1 = !range1 | (cpu.addr[7:0] == dataLow);
   wire rwHit1 = !rwEnable1 | (cpu.rw == rwValue1);
   wire bp1Hit = dataEnable & addrHighHit1 & addrLowHit1 & rwHit1;
   wire dualHit = dualMode & (bp0Hit | bp1Hit);
   wire anyHit = cpu.eFall & !bdmActive & (fullHit | dualHit);
   wire programHit = anyHit & programOnly & cpu.fetch;
   wire dataBreakHit = anyHit & !programOnly;

   // instruction queue tags
   wire queueFull = (fill == (PW + 1)'(QUEUE_DEPTH));
   wire queueEmpty = (fill == '0);
   wire queueWrite = cpu.eFall & cpu.fetch & !queueFull;
   wire queueRead = cpu.queueAdvance & !queueEmpty;
   wire extSample = tagEnable & !bdmActive;
   wire extHigh = extSample & !tagHighPinIn;
   wire extLow = extSample & !tagLowPinIn;
   hbt_pkg::hbt_tag_t newTag;
   assign newTag = '{brkHigh: programHit, brkLow: programHit, extHigh: extHigh, extLow: extLow};
   hbt_pkg::hbt_tag_t headTag;
   assign headTag = tagQueue[rdPtr];
   wire headExt = cpu.headHigh ? headTag.extHigh : headTag.extLow;
   wire headBrk = cpu.headHigh ? headTag.brkHigh : headTag.brkLow;
   wire headLive = cpu.instrStart & !queueEmpty & !bdmActive;
   wire extFire = headLive & headExt;
   wire brkFire = headLive & headBrk;
   wire boundaryFire = cpu.instrStart & breakPending & !bdmActive;
   wire setSwi = brkFire & swiDual & !extFire;
   wire setBdm = extFire | (brkFire & !swiDual) | boundaryFire;
   wire next_breakPending = !bdmActive & (dataBreakHit | (breakPending & !cpu.instrStart));

   // bus slave: zero wait states, response always OKAY
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         writePending <= 1'b0;
         writeAddr <= 8'h00;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (addrPhase & !hwrite)
            hrdata <= {24'h000000, readByte};
         writePending <= addrPhase & hwrite & mapped;
         writeAddr <= regAddr;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         control0 <= hbt_pkg::CONTROL_RESET;
         control1 <= hbt_pkg::CONTROL_RESET;
      end
      else
      begin
         if (wrControl0)
            control0 <= wrByte;
         if (wrControl1)
            control1 <= wrByte;
      end
   end

   // match registers survive plain reset
   always_ff @(posedge clk)
   begin
      if (powerOnReset)
      begin
         addressHigh <= hbt_pkg::MATCH_RESET;
         addressLow <= hbt_pkg::MATCH_RESET;
         dataHigh <= hbt_pkg::MATCH_RESET;
         dataLow <= hbt_pkg::MATCH_RESET;
      end
      else
      begin
         if (wrAddrHigh)
            addressHigh <= wrByte;
         if (wrAddrLow)
            addressLow <= wrByte;
         if (wrDataHigh)
            dataHigh <= wrByte;
         if (wrDataLow)
            dataLow <= wrByte;
      end
   end

   // tag store: written at falling E with the fetched word
   always_ff @(posedge clk)
   begin
      if (reset | cpu.queueFlush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill <= '0;
      end
      else
      begin
         if (queueWrite)
            wrPtr <= (wrPtr == PW'(QUEUE_DEPTH - 1)) ? '0 : wrPtr + PW'(1);
         if (queueRead)
            rdPtr <= (rdPtr == PW'(QUEUE_DEPTH - 1)) ? '0 : rdPtr + PW'(1);
         fill <= fill + (PW + 1)'(queueWrite) - (PW + 1)'(queueRead);
      end
   end

   always_ff @(posedge clk)
   begin
      if (queueWrite)
         tagQueue[wrPtr] <= newTag;
   end

   // requests and tagging state; set wins over clear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         breakPending <= 1'b0;
         swiRequest <= 1'b0;
         bdmRequest <= 1'b0;
         tagEnable <= 1'b0;
         serialHold <= 1'b0;
      end
      else
      begin
         breakPending <= next_breakPending;
         swiRequest <= setSwi | (swiRequest & !swiAccept);
         bdmRequest <= setBdm | (bdmRequest & !bdmAccept);
         tagEnable <= tagGoCommand | (tagEnable & !bdmActive);
         serialHold <= tagGoCommand | (tagEnable & !bdmActive);
      end
   end

   // shared low tag pin: driven only in the strobe window
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         lowStrobeOut <= 1'b1;
         lowStrobeOe_n <= 1'b1;
      end
      else
      begin
         lowStrobeOut <= cpu.lowByteStrobe;
         lowStrobeOe_n <= !cpu.eWindow;
      end
   end

endmodule // hbt_core

// >>> design/hbt_pkg.sv
package hbt_pkg;

   // register byte addresses on the AHB-Lite slave
   localparam logic [7:0] ADDR_CONTROL_0 = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_1 = 8'h04;
   localparam logic [7:0] ADDR_ADDRESS_HIGH = 8'h08;
   localparam logic [7:0] ADDR_ADDRESS_LOW = 8'h0C;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'h10;
   localparam logic [7:0] ADDR_DATA_LOW = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // break_control_0 fields
   localparam int MODE_ENABLE_HI_BIT = 7;
   localparam int MODE_ENABLE_LO_BIT = 6;
   localparam int PROGRAM_ONLY_SELECT_BIT = 5;
   localparam int RANGE_BIT_1_BIT = 1;
   localparam int RANGE_BIT_0_BIT = 0;

   // break_control_1 fields
   localparam int DATA_COMPARE_ENABLE_BIT = 6;
   localparam int HIGH_BYTE_MASK_BIT = 5;
   localparam int LOW_BYTE_MASK_BIT = 4;
   localparam int RW_COMPARE_ENABLE_1_BIT = 3;
   localparam int RW_COMPARE_VALUE_1_BIT = 2;
   localparam int RW_COMPARE_ENABLE_0_BIT = 1;
   localparam int RW_COMPARE_VALUE_0_BIT = 0;

   // status fields (read only)
   localparam int STATUS_TAG_ENABLE_BIT = 0;
   localparam int STATUS_BREAK_PENDING_BIT = 1;
   localparam int STATUS_BDM_REQUEST_BIT = 2;
   localparam int STATUS_SWI_REQUEST_BIT = 3;

   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] MATCH_RESET = 8'h00;
   localparam int QUEUE_DEPTH_DEFAULT = 4;

   // value of the two mode-enable bits
   typedef enum logic [1:0] {
      HBT_MODE_OFF = 2'h0,
      HBT_MODE_SWI_DUAL = 2'h1,
      HBT_MODE_BDM_FULL = 2'h2,
      HBT_MODE_BDM_DUAL = 2'h3
   } hbt_mode_t;

   // cpu-side bus cycle view, sampled once per clk
   typedef struct packed {
      logic eFall;         // pulse: falling edge of e_bus_clock
      logic eWindow;       // level: quarter cycle around rising e_bus_clock
      logic lowByteStrobe; // value the cpu wants on low_byte_strobe
      logic fetch;         // this bus cycle fetches a program word
      logic rw;            // 1 read, 0 write
      logic [15:0] addr;
      logic [15:0] data;
      logic queueAdvance;  // pulse: queue head word retired
      logic queueFlush;    // pulse: queue discarded (change of flow)
      logic instrStart;    // pulse: instruction at head about to execute
      logic headHigh;      // opcode at head sits in high byte
   } hbt_cpu_t;

   typedef struct packed {
      logic brkHigh;
      logic brkLow;
      logic extHigh;
      logic extLow;
   } hbt_tag_t;

endpackage

// >>> testbench/hbt_core_sva.sv
`timescale 1ns/1ps
module hbt_core_sva #(
   parameter int QUEUE_DEPTH = hbt_pkg::QUEUE_DEPTH_DEFAULT
) (
   input wire logic clk,
   input wire logic reset,
   input wire hbt_pkg::hbt_cpu_t cpu,
   input wire logic bdmActive,
   input wire logic tagGoCommand,
   input wire logic swiAccept,
   input wire logic bdmAccept,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic lowStrobeOut,
   input wire logic lowStrobeOe_n,
   input wire logic swiRequest,
   input wire logic bdmRequest,
   input wire logic tagEnable,
   input wire logic serialHold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence armed;
      tagEnable && serialHold;
   endsequence
   sequence disarmed;
      !tagEnable && !serialHold;
   endsequence
   okay_resp_a: assert property (hresp == 1'b0) else $error("error response");
   ready_after_a: assert property (1'b1 |=> hreadyout) else $error("hreadyout low");
   strobe_follow_a: assert property (1'b1 |=> lowStrobeOut == $past(cpu.lowByteStrobe)) else $error("strobe");
   strobe_window_a: assert property (1'b1 |=> lowStrobeOe_n == !$past(cpu.eWindow)) else $error("window");
   tag_arm_a: assert property (tagGoCommand |=> armed) else $error("tag not armed");
   tag_drop_a: assert property (bdmActive && !tagGoCommand |=> disarmed) else $error("tag kept");
   swi_hold_a: assert property (swiRequest && !swiAccept |=> swiRequest) else $error("swi dropped");
   bdm_hold_a: assert property (bdmRequest && !bdmAccept |=> bdmRequest) else $error("bdm dropped");
   swi_cause_a: assert property ($rose(swiRequest) |-> $past(cpu.instrStart)) else $error("swi early");
endmodule // hbt_core_sva
bind hbt_core hbt_core_sva #(.QUEUE_DEPTH(QUEUE_DEPTH)) i_hbt_core_sva (.clk(clk), .reset(reset), .cpu(cpu),
   .bdmActive(bdmActive), .tagGoCommand(tagGoCommand), .swiAccept(swiAccept), .bdmAccept(bdmAccept),
   .hreadyout(hreadyout), .hresp(hresp), .lowStrobeOut(lowStrobeOut), .lowStrobeOe_n(lowStrobeOe_n),
   .swiRequest(swiRequest), .bdmRequest(bdmRequest), .tagEnable(tagEnable), .serialHold(serialHold));

// >>> testbench/hbt_cpu_model.sv
`timescale 1ns/1ps
module hbt_cpu_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] op,
   input wire logic [15:0] addr,
   input wire logic rw,
   input wire logic [15:0] data,
   input wire logic slow,
   input wire logic tag_high_pin,
   input wire logic tag_low_pin,
   input wire logic lowStrobeOut,
   input wire logic lowStrobeOe_n,
   input wire logic swiRequest,
   input wire logic bdmRequest,
   output hbt_pkg::hbt_cpu_t cpu,
   output logic bdmActive,
   output logic swiAccept,
   output logic bdmAccept,
   output logic tagHighPinIn,
   output logic tagLowPinIn
);
   logic [1:0] ph;
   logic [1:0] pend;
   logic [4:0] bdmCount;
   logic fire;
   assign fire = ph == 2'h3;
   assign bdmActive = bdmCount != 5'h0;
   assign tagHighPinIn = tag_high_pin;
   // tool level reaches the pin only outside the strobe window
   assign tagLowPinIn = lowStrobeOe_n ? tag_low_pin : lowStrobeOut;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ph <= 2'h0;
         pend <= 2'h0;
         cpu <= '0;
         bdmCount <= 5'h0;
         swiAccept <= 1'b0;
         bdmAccept <= 1'b0;
      end
      else
      begin
         ph <= ph + 2'h1;
         pend <= (op != 2'h0) ? op : (fire ? 2'h0 : pend);
         cpu.eFall <= fire && (pend == 2'h1 || pend == 2'h2);
         cpu.fetch <= fire && pend == 2'h1;
         cpu.instrStart <= fire && pend == 2'h3;
         cpu.queueAdvance <= cpu.instrStart;
         cpu.eWindow <= ph == 2'h0;
         cpu.lowByteStrobe <= ph[1];
         cpu.addr <= addr;
         cpu.rw <= rw;
         cpu.data <= data;
         cpu.headHigh <= !addr[0];
         // slow answers wait for the end of an E cycle
         swiAccept <= swiRequest && !swiAccept && (!slow || fire);
         bdmAccept <= bdmRequest && !bdmAccept && !bdmActive && (!slow || fire);
         bdmCount <= bdmAccept ? 5'h1F : bdmCount - {4'h0, bdmActive};
      end
   end
endmodule // hbt_cpu_model

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic [47:0] regs;
      logic [1:0] kind;
      logic [15:0] addr;
      logic rw;
      logic [15:0] data;
      logic swi;
      logic background_debug_mode;
   } hbt_row_t;
   hbt_row_t rows [15] = '{
      '{48'h000012340000, 2'h1, 16'h1234, 1'b1, 16'h0, 1'b0, 1'b0},
      '{48'h410012340000, 2'h1, 16'h1234, 1'b1, 16'h0, 1'b1, 1'b0},
      '{48'h410012340000, 2'h1, 16'h1235, 1'b1, 16'h0, 1'b0, 1'b0},
      '{48'h400012340000, 2'h1, 16'h12FF, 1'b1, 16'h0, 1'b1, 1'b0},
      '{48'h4240AA005678, 2'h1, 16'h5678, 1'b1, 16'h0, 1'b1, 1'b0},
      '{48'h4200AA005678, 2'h1, 16'h5678, 1'b1, 16'h0, 1'b0, 1'b0},
      '{48'h410012340000, 2'h2, 16'h1234, 1'b1, 16'h0, 1'b0, 1'b0},
      '{48'h814312345678, 2'h2, 16'h1234, 1'b1, 16'h5678, 1'b0, 1'b1},
      '{48'h814012345678, 2'h2, 16'h1234, 1'b1, 16'h5679, 1'b0, 1'b0},
      '{48'h815012345678, 2'h2, 16'h1234, 1'b1, 16'h5699, 1'b0, 1'b1},
      '{48'h810312340000, 2'h2, 16'h1234, 1'b0, 16'h0, 1'b0, 1'b0},
      '{48'hA14012345678, 2'h2, 16'h1234, 1'b1, 16'h5678, 1'b0, 1'b0},
      '{48'hA14012345678, 2'h1, 16'h1234, 1'b1, 16'h0, 1'b0, 1'b1},
      '{48'hC24CAA005678, 2'h2, 16'h5678, 1'b0, 16'h0, 1'b0, 1'b0},
      '{48'hC24CAA005678, 2'h2, 16'h5678, 1'b1, 16'h0, 1'b0, 1'b1}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic powerOnReset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] op = 2'h0;
   logic [15:0] addr = 16'h0;
   logic [15:0] data = 16'h0;
   logic rw = 1'b1;
   logic slow = 1'b0;
   logic tag_high_pin = 1'b1;
   logic tag_low_pin = 1'b1;
   logic tagGoCommand = 1'b0;
   logic hreadyout, hresp, lowStrobeOut, lowStrobeOe_n, swiRequest, bdmRequest, tagEnable, serialHold;
   logic bdmActive, swiAccept, bdmAccept, tagHighPinIn, tagLowPinIn;
   logic [31:0] hrdata, rd;
   hbt_pkg::hbt_cpu_t cpu;
   int n_errors = 0;
   int compares = 0;
   int swiN = 0;
   int bdmN = 0;
   int s0, b0;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      swiN <= swiN + int'(swiRequest);
      bdmN <= bdmN + int'(bdmRequest);
   end
   hbt_core i_hbt_core (.clk(clk), .reset(reset), .powerOnReset(powerOnReset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .cpu(cpu), .bdmActive(bdmActive), .tagGoCommand(tagGoCommand),
      .tagHighPinIn(tagHighPinIn), .tagLowPinIn(tagLowPinIn), .lowStrobeOut(lowStrobeOut),
      .lowStrobeOe_n(lowStrobeOe_n), .swiAccept(swiAccept), .bdmAccept(bdmAccept), .swiRequest(swiRequest),
      .bdmRequest(bdmRequest), .tagEnable(tagEnable), .serialHold(serialHold));
   hbt_cpu_model i_hbt_cpu_model (.clk(clk), .reset(reset), .op(op), .addr(addr), .rw(rw), .data(data),
      .slow(slow), .tag_high_pin(tag_high_pin), .tag_low_pin(tag_low_pin), .lowStrobeOut(lowStrobeOut), .lowStrobeOe_n(lowStrobeOe_n),
      .swiRequest(swiRequest), .bdmRequest(bdmRequest), .cpu(cpu), .bdmActive(bdmActive),
      .swiAccept(swiAccept), .bdmAccept(bdmAccept), .tagHighPinIn(tagHighPinIn), .tagLowPinIn(tagLowPinIn));
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic doReset(input logic por);
      reset <= 1'b1;
      powerOnReset <= por;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      powerOnReset <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   // the model holds the request until its E cycle comes round
   task automatic cpuOp(input logic [1:0] o);
      op <= o;
      @(posedge clk);
      op <= 2'h0;
      repeat (8) @(posedge clk);
   endtask
   initial
   begin
      doReset(1'b1);
      for (int i = 0; i < 15; i++)
      begin
         doReset(1'b0);
         for (int k = 0; k < 6; k++)
            ahb(1'b1, 8'(k * 4), rows[i].regs[47 - 8 * k -: 8], rd);
         addr <= rows[i].addr;
         rw <= rows[i].rw;
         data <= rows[i].data;
         s0 = swiN;
         b0 = bdmN;
         cpuOp(rows[i].kind);
         cpuOp(2'h3);
         check("swi", 32'(swiN != s0), 32'(rows[i].swi));
         check("bdm", 32'(bdmN != b0), 32'(rows[i].background_debug_mode));
      end
      ahb(1'b1, hbt_pkg::ADDR_ADDRESS_HIGH, 8'h12, rd);
      doReset(1'b0);
      ahb(1'b0, hbt_pkg::ADDR_ADDRESS_HIGH, 8'h0, rd);
      check("keep", rd, 32'h12);
      ahb(1'b0, hbt_pkg::ADDR_CONTROL_0, 8'h0, rd);
      check("ctl0", rd, 32'(hbt_pkg::CONTROL_RESET));
      ahb(1'b1, hbt_pkg::ADDR_CONTROL_1, 8'h7F, rd);
      ahb(1'b0, hbt_pkg::ADDR_CONTROL_1, 8'h0, rd);
      check("ctl1", rd, 32'h7F);
      ahb(1'b0, 8'h1C, 8'h0, rd);
      check("unmapped", rd, 32'h0);
      doReset(1'b1);
      ahb(1'b0, hbt_pkg::ADDR_ADDRESS_HIGH, 8'h0, rd);
      check("por", rd, 32'(hbt_pkg::MATCH_RESET));
      ahb(1'b1, hbt_pkg::ADDR_ADDRESS_HIGH, 8'h12, rd);
      ahb(1'b1, hbt_pkg::ADDR_CONTROL_0, 8'h40, rd);
      slow <= 1'b1;
      tagGoCommand <= 1'b1;
      @(posedge clk);
      tagGoCommand <= 1'b0;
      @(posedge clk);
      check("armed", 32'(tagEnable & serialHold), 32'h1);
      ahb(1'b0, hbt_pkg::ADDR_STATUS, 8'h0, rd);
      check("status", rd, 32'h1);
      addr <= 16'h2000;
      tag_high_pin <= 1'b0;
      b0 = bdmN;
      cpuOp(2'h1);
      tag_high_pin <= 1'b1;
      cpuOp(2'h3);
      repeat (6) @(posedge clk);
      check("tagBdm", 32'(bdmN != b0), 32'h1);
      check("tagOff", 32'(tagEnable), 32'h0);
      addr <= 16'h1234;
      s0 = swiN;
      cpuOp(2'h1);
      cpuOp(2'h3);
      check("inBdm", 32'(swiN != s0), 32'h0);
      // let background mode run out before arming the low tag pin
      repeat (20) @(posedge clk);
      tagGoCommand <= 1'b1;
      @(posedge clk);
      tagGoCommand <= 1'b0;
      addr <= 16'h2001;
      tag_low_pin <= 1'b0;
      b0 = bdmN;
      cpuOp(2'h1);
      tag_low_pin <= 1'b1;
      cpuOp(2'h3);
      repeat (6) @(posedge clk);
      check("tagLow", 32'(bdmN != b0), 32'h1);
      end_of_test();
   end
   initial
   begin
      #100000;
      n_errors++;
      end_of_test();
   end
endmodule // tb
